// ---- plt_pkg.sv ----
// plt_pkg: constants, types and carriers for the phy link training control bank.
// assumes a 32-bit register port with 12-bit byte addresses and one 20 MHz core clock.
package plt_pkg;

  // register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] PLT_CFG_UPPER_OFS   = 12'h530;
  localparam logic [ADDR_W-1:0] PLT_STATE_CTL_OFS   = 12'h540;
  localparam logic [ADDR_W-1:0] PLT_RETRAIN_DLY_OFS = 12'h544;
  localparam logic [ADDR_W-1:0] PLT_STATUS_OFS      = 12'h548;
  localparam logic [ADDR_W-1:0] PLT_SEED_OFS        = 12'h55C;

  // field positions
  localparam int INITIAL_SPEED_CHANGE_CTRL_BIT   = 14;
  localparam int WUC_BIT     = 15;
  localparam int RETRAIN_BIT = 31;
  localparam int SEED_W      = 16;
  localparam int DLY_W       = 16;
  localparam int ST_STATE_LO = 0;
  localparam int ST_STATE_HI = 2;
  localparam int ST_GEN2_BIT = 3;
  localparam int ST_PEND_BIT = 4;
  localparam int ST_SWWR_BIT = 5;

  // reset values
  localparam logic              INITIAL_SPEED_CHANGE_CTRL_DSP_RST   = 1'h0;
  localparam logic              INITIAL_SPEED_CHANGE_CTRL_OTHER_RST = 1'h1;
  localparam logic              WUC_RST         = 1'h0;
  localparam logic [SEED_W-1:0] SEED_RST        = 16'hFFFF;
  localparam logic [DLY_W-1:0]  DLY_RST         = 16'h0400;
  localparam logic [DLY_W-1:0]  DLY_ZERO        = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO       = 32'h0000_0000;

  // galois feedback for x^16+x^14+x^13+x^11+1
  localparam logic [SEED_W-1:0] PRBS_TAPS = 16'hB400;

  // port operating mode as strapped by the switch core
  typedef enum logic [1:0] {
    PLT_MODE_USP   = 2'h0,
    PLT_MODE_DSP   = 2'h1,
    PLT_MODE_NT    = 2'h2,
    PLT_MODE_OTHER = 2'h3
  } plt_mode_t;

  // training state machine
  typedef enum logic [2:0] {
    PLT_ST_DETECT,
    PLT_ST_POLLING,
    PLT_ST_CONFIG,
    PLT_ST_L0,
    PLT_ST_RECOVERY
  } plt_state_t;

  // status reported by the lane logic
  typedef struct packed {
    logic      rx_detect;
    logic      poll_done;
    logic      cfg_done;
    logic      recov_done;
    logic      gen2_permit;
    logic      crosslink;
    plt_mode_t mode;
  } plt_phy_in_t;

  // controls handed to the lane logic
  typedef struct packed {
    plt_state_t state;
    logic       gen2_rate;
    logic       speed_change_req;
    logic       upconfig_adv;
    logic       in_detect;
  } plt_phy_out_t;

  localparam int PHY_IN_W = $bits(plt_phy_in_t);

endpackage : plt_pkg

// ---- plt_link_ctrl.sv ----
// plt_link_ctrl: register bank and training sequencer for one switch port's phy.
// assumes phy_i comes from another clock domain and the register port is on clk_i.
//
// What this block does
// - control bit 0: after first L0 from detect, change to gen2 if permitted
// - control bit 1: never start an automatic rate change, stay at gen1
// - control bit resets to 0 on a downstream port, 1 in every other mode
// - once software writes the control bit, mode changes no longer alter it
// - crosslinked upstream ports with the bit set both stay at gen1
// - an upstream port with the bit cleared starts the gen2 change itself
// - width-upconfig disable set hides upconfig support in Config training sets
// - writing one to the full-retrain bit forces training back to detect
// - full-retrain bit always reads zero
// - the write completes before the retrain takes effect
// - on an upstream port the retrain waits for a programmed delay
// - 16-bit sequence seed, resets to all ones, drives crosslink generator
// - writing the seed reloads the sequence counter, which then resumes
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module plt_link_ctrl (
  // clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           resetn_i,
  // register port
  input  wire logic [plt_pkg::ADDR_W-1:0]     addr_i,
  input  wire logic [plt_pkg::DATA_W-1:0]     wdata_i,
  input  wire logic                           we_i,
  input  wire logic                           re_i,
  output logic      [plt_pkg::DATA_W-1:0]     rdata_o,
  // lane logic
  input  wire plt_pkg::plt_phy_in_t           phy_i,
  output var  plt_pkg::plt_phy_out_t          phy_o,
  output logic      [plt_pkg::SEED_W-1:0]     prbs_o
);
  import plt_pkg::*;

  // one galois step of the crosslink sequence
  function automatic logic [SEED_W-1:0] lfsr_step(input logic [SEED_W-1:0] cur);
    lfsr_step = {1'h0, cur[SEED_W-1:1]} ^ (cur[0] ? PRBS_TAPS : {SEED_W{1'h0}});
  endfunction : lfsr_step

  // reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // lane status crossing: three stages, a change counts once stages two and three agree
  logic [PHY_IN_W-1:0] sync1_reg;
  logic [PHY_IN_W-1:0] sync2_reg;
  logic [PHY_IN_W-1:0] sync3_reg;
  logic [PHY_IN_W-1:0] filt_reg;
  logic [PHY_IN_W-1:0] filt_next;
  plt_phy_in_t         ph;

  always_comb begin
    filt_next = (filt_reg & (sync2_reg ^ sync3_reg)) | (sync3_reg & ~(sync2_reg ^ sync3_reg));
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg  <= '0;
    end else begin
      sync1_reg <= phy_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  assign ph = plt_phy_in_t'(filt_reg);

  // register write decode
  logic wr_cfg;
  logic wr_ctl;
  logic wr_dly;
  logic wr_seed;

  assign wr_cfg  = we_i && (addr_i == PLT_CFG_UPPER_OFS);
  assign wr_ctl  = we_i && (addr_i == PLT_STATE_CTL_OFS);
  assign wr_dly  = we_i && (addr_i == PLT_RETRAIN_DLY_OFS);
  assign wr_seed = we_i && (addr_i == PLT_SEED_OFS);

  // configuration fields
  logic              initial_speed_change_ctrl_reg;
  logic              initial_speed_change_ctrl_next;
  logic              initial_speed_change_ctrl_sw_reg;
  logic              initial_speed_change_ctrl_sw_next;
  logic              wuc_reg;
  logic              wuc_next;
  logic [DLY_W-1:0]  dly_reg;
  logic [DLY_W-1:0]  dly_next;
  logic [SEED_W-1:0] seed_reg;
  logic [SEED_W-1:0] seed_next;

  always_comb begin
    initial_speed_change_ctrl_next    = initial_speed_change_ctrl_reg;
    initial_speed_change_ctrl_sw_next = initial_speed_change_ctrl_sw_reg;
    wuc_next      = wuc_reg;
    dly_next      = dly_reg;
    seed_next     = seed_reg;
    if (wr_cfg) begin
      initial_speed_change_ctrl_next    = wdata_i[INITIAL_SPEED_CHANGE_CTRL_BIT];
      initial_speed_change_ctrl_sw_next = 1'h1;
      wuc_next      = wdata_i[WUC_BIT];
    end else if (!initial_speed_change_ctrl_sw_reg) begin
      // until software owns the bit, it tracks the strapped mode
      initial_speed_change_ctrl_next = (ph.mode == PLT_MODE_DSP) ? INITIAL_SPEED_CHANGE_CTRL_DSP_RST : INITIAL_SPEED_CHANGE_CTRL_OTHER_RST;
    end
    if (wr_dly) begin
      dly_next = wdata_i[DLY_W-1:0];
    end
    if (wr_seed) begin
      seed_next = wdata_i[SEED_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      initial_speed_change_ctrl_reg    <= INITIAL_SPEED_CHANGE_CTRL_OTHER_RST;
      initial_speed_change_ctrl_sw_reg <= 1'h0;
      wuc_reg      <= WUC_RST;
      dly_reg      <= DLY_RST;
      seed_reg     <= SEED_RST;
    end else begin
      initial_speed_change_ctrl_reg    <= initial_speed_change_ctrl_next;
      initial_speed_change_ctrl_sw_reg <= initial_speed_change_ctrl_sw_next;
      wuc_reg      <= wuc_next;
      dly_reg      <= dly_next;
      seed_reg     <= seed_next;
    end
  end

  // full retrain: the write is accepted in its own cycle, the effect lands later
  logic             pend_reg;
  logic             pend_next;
  logic [DLY_W-1:0] dcnt_reg;
  logic [DLY_W-1:0] dcnt_next;
  logic             retrain_fire;

  // downstream ports fire one cycle after the write; upstream ports wait out the delay
  assign retrain_fire = pend_reg && ((ph.mode != PLT_MODE_USP) || (dcnt_reg == DLY_ZERO));

  always_comb begin
    pend_next = pend_reg;
    dcnt_next = dcnt_reg;
    if (retrain_fire) begin
      pend_next = 1'h0;
    end else if (pend_reg && (dcnt_reg != DLY_ZERO)) begin
      dcnt_next = dcnt_reg - 16'h0001;
    end
    // a fresh request in the firing cycle is kept and restarts the delay
    if (wr_ctl && wdata_i[RETRAIN_BIT]) begin
      pend_next = 1'h1;
      dcnt_next = dly_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'h0;
      dcnt_reg <= DLY_ZERO;
    end else begin
      pend_reg <= pend_next;
      dcnt_reg <= dcnt_next;
    end
  end

  // training sequencer
  plt_state_t   state_reg;
  plt_state_t   state_next;
  logic         gen2_reg;
  logic         gen2_next;
  logic         fresh_reg;
  logic         fresh_next;
  plt_phy_out_t out_reg;
  plt_phy_out_t out_next;

  always_comb begin
    state_next = state_reg;
    gen2_next  = gen2_reg;
    fresh_next = fresh_reg;
    if (retrain_fire) begin
      state_next = PLT_ST_DETECT;
      gen2_next  = 1'h0;
      fresh_next = 1'h1;
    end else begin
      case (state_reg)
        PLT_ST_DETECT: begin
          gen2_next  = 1'h0;
          fresh_next = 1'h1;
          if (ph.rx_detect) begin
            state_next = PLT_ST_POLLING;
          end
        end
        PLT_ST_POLLING: begin
          if (!ph.rx_detect) begin
            state_next = PLT_ST_DETECT;
          end else if (ph.poll_done) begin
            state_next = PLT_ST_CONFIG;
          end
        end
        PLT_ST_CONFIG: begin
          if (!ph.rx_detect) begin
            state_next = PLT_ST_DETECT;
          end else if (ph.cfg_done) begin
            state_next = PLT_ST_L0;
          end
        end
        PLT_ST_L0: begin
          if (!ph.rx_detect) begin
            state_next = PLT_ST_DETECT;
          end else if (fresh_reg) begin
            // only the first arrival from detect may start an automatic change;
            // the same test applies to upstream ports, crosslinked or not
            fresh_next = 1'h0;
            if (!initial_speed_change_ctrl_reg && ph.gen2_permit && !gen2_reg) begin
              state_next = PLT_ST_RECOVERY;
            end
          end
        end
        PLT_ST_RECOVERY: begin
          if (!ph.rx_detect) begin
            state_next = PLT_ST_DETECT;
          end else if (ph.recov_done) begin
            gen2_next  = 1'h1;
            state_next = PLT_ST_L0;
          end
        end
        default: begin
          state_next = PLT_ST_DETECT;
        end
      endcase
    end
    // with the control bit set no path leads to recovery, so the rate stays gen1
    out_next.state            = state_next;
    out_next.gen2_rate        = gen2_next;
    out_next.speed_change_req = (state_next == PLT_ST_RECOVERY);
    out_next.upconfig_adv     = (state_next == PLT_ST_CONFIG) && !wuc_reg;
    out_next.in_detect        = (state_next == PLT_ST_DETECT);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PLT_ST_DETECT;
      gen2_reg  <= 1'h0;
      fresh_reg <= 1'h1;
      out_reg   <= '{state: PLT_ST_DETECT, gen2_rate: 1'h0, speed_change_req: 1'h0,
                     upconfig_adv: 1'h0, in_detect: 1'h1};
    end else begin
      state_reg <= state_next;
      gen2_reg  <= gen2_next;
      fresh_reg <= fresh_next;
      out_reg   <= out_next;
    end
  end

  assign phy_o = out_reg;

  // crosslink sequence; an all-zero seed locks the generator at zero
  logic [SEED_W-1:0] prbs_reg;
  logic [SEED_W-1:0] prbs_next;

  always_comb begin
    prbs_next = prbs_reg;
    if (wr_seed) begin
      prbs_next = wdata_i[SEED_W-1:0];
    end else if (ph.crosslink) begin
      prbs_next = lfsr_step(prbs_reg);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prbs_reg <= SEED_RST;
    end else begin
      prbs_reg <= prbs_next;
    end
  end

  assign prbs_o = prbs_reg;

  // read path: data stands only in the cycle after the strobe
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  always_comb begin
    rd_val = DATA_ZERO;
    case (addr_i)
      PLT_CFG_UPPER_OFS: begin
        rd_val[INITIAL_SPEED_CHANGE_CTRL_BIT] = initial_speed_change_ctrl_reg;
        rd_val[WUC_BIT]   = wuc_reg;
      end
      PLT_STATE_CTL_OFS: begin
        rd_val = DATA_ZERO;
      end
      PLT_RETRAIN_DLY_OFS: begin
        rd_val[DLY_W-1:0] = dly_reg;
      end
      PLT_STATUS_OFS: begin
        rd_val[ST_STATE_HI:ST_STATE_LO] = state_reg;
        rd_val[ST_GEN2_BIT]             = gen2_reg;
        rd_val[ST_PEND_BIT]             = pend_reg;
        rd_val[ST_SWWR_BIT]             = initial_speed_change_ctrl_sw_reg;
      end
      PLT_SEED_OFS: begin
        rd_val[SEED_W-1:0] = seed_reg;
      end
      default: begin
        rd_val = DATA_ZERO;
      end
    endcase
    rdata_next = re_i ? rd_val : DATA_ZERO;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= DATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

endmodule : plt_link_ctrl

`default_nettype wire

// ---- plt_link_ctrl_checker.sv ----
// plt_link_ctrl_checker: port-level timing relations of the training control bank.
// assumes it is bound to plt_link_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module plt_link_ctrl_checker (
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       resetn_i,
  // register port
  input wire logic [plt_pkg::ADDR_W-1:0] addr_i,
  input wire logic [plt_pkg::DATA_W-1:0] wdata_i,
  input wire logic                       we_i,
  input wire logic                       re_i,
  input wire logic [plt_pkg::DATA_W-1:0] rdata_o,
  // lane logic
  input wire plt_pkg::plt_phy_in_t       phy_i,
  input wire plt_pkg::plt_phy_out_t      phy_o,
  input wire logic [plt_pkg::SEED_W-1:0] prbs_o
);
  import plt_pkg::*;
  wire logic [SEED_W-1:0] seed_w = wdata_i[SEED_W-1:0];
  wire plt_state_t        st     = phy_o.state;
  wire logic              g2     = phy_o.gen2_rate;
  wire logic              rt_wr  = we_i && addr_i == PLT_STATE_CTL_OFS && wdata_i[RETRAIN_BIT];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  property p_rd_idle;
    !$past(re_i) |-> rdata_o == DATA_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rt_zero;
    re_i && addr_i == PLT_STATE_CTL_OFS |=> rdata_o == DATA_ZERO;
  endproperty
  a_rt_zero: assert property (p_rt_zero)
    else $error("retrain register not zero");
  property p_seed_rsv;
    re_i && addr_i == PLT_SEED_OFS |=> rdata_o[31:16] == 16'h0000;
  endproperty
  a_seed_rsv: assert property (p_seed_rsv)
    else $error("seed upper half not zero");
  property p_seed_load;
    we_i && addr_i == PLT_SEED_OFS |=> prbs_o == $past(seed_w);
  endproperty
  a_seed_load: assert property (p_seed_load)
    else $error("sequence not reloaded");
  property p_rt_late;
    rt_wr |=> st == $past(st);
  endproperty
  a_rt_late: assert property (p_rt_late)
    else $error("retrain acted with its write");
  property p_req;
    phy_o.speed_change_req == (st == PLT_ST_RECOVERY);
  endproperty
  a_req: assert property (p_req)
    else $error("speed request out of recovery");
  property p_adv;
    phy_o.upconfig_adv |-> st == PLT_ST_CONFIG;
  endproperty
  a_adv: assert property (p_adv)
    else $error("upconfig advertised outside config");
  property p_det;
    phy_o.in_detect == (st == PLT_ST_DETECT);
  endproperty
  a_det: assert property (p_det)
    else $error("detect flag wrong");
  property p_gen2;
    $rose(g2) |-> $past(st) == PLT_ST_RECOVERY;
  endproperty
  a_gen2: assert property (p_gen2)
    else $error("gen2 without recovery");
  c_recov: cover property (st == PLT_ST_RECOVERY);
  c_rt: cover property (rt_wr);
  c_seed: cover property (we_i && addr_i == PLT_SEED_OFS);
endmodule : plt_link_ctrl_checker
bind plt_link_ctrl plt_link_ctrl_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
  .phy_i(phy_i), .phy_o(phy_o), .prbs_o(prbs_o));
`default_nettype wire

// ---- plt_lane_model.sv ----
// plt_lane_model: lane-side stand-in that closes the training loop.
// assumes the bench sets receiver presence, crosslink and port mode.
`timescale 1ns/1ps
`default_nettype none
module plt_lane_model (
  // training controls from the sequencer
  input  wire plt_pkg::plt_phy_out_t ctl_i,
  // bench levels
  input  wire logic                  det_i,
  input  wire logic                  xl_i,
  input  wire plt_pkg::plt_mode_t    mode_i,
  // status back to the sequencer
  output var  plt_pkg::plt_phy_in_t  st_o
);
  import plt_pkg::*;
  // done flags hold for the whole state, well beyond the sync filter
  always_comb begin
    st_o.rx_detect   = det_i;
    st_o.poll_done   = ctl_i.state == PLT_ST_POLLING;
    st_o.cfg_done    = ctl_i.state == PLT_ST_CONFIG;
    st_o.recov_done  = ctl_i.state == PLT_ST_RECOVERY;
    st_o.gen2_permit = 1'b1;
    st_o.crosslink   = xl_i;
    st_o.mode        = mode_i;
  end
endmodule : plt_lane_model
`default_nettype wire

// ---- plt_link_ctrl_test.sv ----
// plt_link_ctrl_test: register-level bench for the phy training controls.
// assumes the lane model answers training and a 50 ns core clock.
`timescale 1ns/1ps
`default_nettype none
module plt_link_ctrl_test;
  import plt_pkg::*;
  logic              clk_i    = 1'b0;
  logic              resetn_i = 1'b0;
  logic [ADDR_W-1:0] addr_i   = 12'h000;
  logic [DATA_W-1:0] wdata_i  = 32'h0;
  logic              we_i     = 1'b0;
  logic              re_i     = 1'b0;
  logic              det      = 1'b0;
  logic              xl       = 1'b0;
  logic              adv      = 1'b0;
  logic              adv_clr  = 1'b0;
  plt_mode_t         mode     = PLT_MODE_DSP;
  logic [DATA_W-1:0] rdata_o;
  plt_phy_in_t       phy_i;
  plt_phy_out_t      phy_o;
  logic [SEED_W-1:0] prbs_o;
  int                failures = 0;
  int                checks   = 0;
  int                n;
  always #25 clk_i = ~clk_i;
  // one driver for the sticky advertise flag; the stimulus clears it through adv_clr
  always @(posedge clk_i) begin
    if (adv_clr) adv <= 1'b0;
    else if (phy_o.upconfig_adv === 1'b1) adv <= 1'b1;
  end
  plt_lane_model u_lane (.ctl_i(phy_o), .det_i(det), .xl_i(xl), .mode_i(mode), .st_o(phy_i));
  plt_link_ctrl DUT (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .phy_i(phy_i), .phy_o(phy_o), .prbs_o(prbs_o));
  task automatic close_out();
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string m);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s got %h", $time, m, g);
    end
  endtask : cmp
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_i);
    we_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string m);
    @(posedge clk_i);
    re_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 cmp(rdata_o, e, m);
  endtask : rd
  // a hung training loop ends the run instead of stalling it
  task automatic wait_st(input plt_state_t s);
    n = 0;
    while (phy_o.state !== s && n < 400) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n >= 400) begin
      cmp(32'h0, 32'h1, "state wait");
      close_out();
    end
  endtask : wait_st
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rd(PLT_SEED_OFS, 32'h0000_FFFF, "seed reset");
    rd(PLT_STATE_CTL_OFS, 32'h0, "retrain readback");
    rd(PLT_CFG_UPPER_OFS, 32'h0, "dsp default");
    mode <= PLT_MODE_USP;
    repeat (10) @(posedge clk_i);
    rd(PLT_CFG_UPPER_OFS, 32'h0000_4000, "usp default");
    wr(PLT_CFG_UPPER_OFS, 32'hFFFF_FFFF);
    rd(PLT_CFG_UPPER_OFS, 32'h0000_C000, "cfg reserved");
    wr(PLT_CFG_UPPER_OFS, 32'h0);
    mode <= PLT_MODE_OTHER;
    repeat (10) @(posedge clk_i);
    rd(PLT_CFG_UPPER_OFS, 32'h0, "sticky speed bit");
    rd(12'h7F0, 32'h0, "unmapped");
    mode <= PLT_MODE_USP;
    wr(PLT_RETRAIN_DLY_OFS, 32'hFFFF_0008);
    rd(PLT_RETRAIN_DLY_OFS, 32'h0000_0008, "delay reserved");
    det <= 1'b1;
    wait_st(PLT_ST_RECOVERY);
    wait_st(PLT_ST_L0);
    cmp({31'h0, phy_o.gen2_rate}, 32'h1, "gen2 after first L0");
    // status: L0, gen2 reached, nothing pending, speed bit owned by software
    rd(PLT_STATUS_OFS, 32'h0000_002B, "status after speed change");
    wr(PLT_STATE_CTL_OFS, 32'h8000_0000);
    n = 0;
    while (phy_o.in_detect !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1 n++;
    end
    cmp({31'h0, n >= 9 && n <= 11}, 32'h1, "retrain delay");
    adv_clr <= 1'b1;
    xl      <= 1'b1;
    @(posedge clk_i);
    adv_clr <= 1'b0;
    wr(PLT_CFG_UPPER_OFS, 32'h0000_4000);
    wait_st(PLT_ST_L0);
    repeat (20) @(posedge clk_i);
    #1 cmp({31'h0, phy_o.gen2_rate}, 32'h0, "gen1 kept");
    cmp({31'h0, adv}, 32'h1, "upconfig advertised");
    wr(PLT_CFG_UPPER_OFS, 32'h0000_C000);
    adv_clr <= 1'b1;
    @(posedge clk_i);
    adv_clr <= 1'b0;
    wr(PLT_STATE_CTL_OFS, 32'h8000_0000);
    wait_st(PLT_ST_DETECT);
    wait_st(PLT_ST_L0);
    cmp({31'h0, adv}, 32'h0, "upconfig hidden");
    wr(PLT_SEED_OFS, 32'h1234_ACE1);
    #1 cmp({16'h0, prbs_o}, 32'h0000_ACE1, "seed reload");
    @(posedge clk_i);
    #1 cmp({16'h0, prbs_o}, 32'h0000_E270, "sequence step");
    rd(PLT_SEED_OFS, 32'h0000_ACE1, "seed readback");
    close_out();
  end
endmodule : plt_link_ctrl_test
`default_nettype wire
